// [src/rcs_defs.svh]
// Register offsets, field positions, reset and preset values of the clock switch supervisor
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH
`define RCS_IDX_OUTCFG     3'd1
`define RCS_IDX_MODE       3'd2
`define RCS_IDX_DEVCFG     3'd3
`define RCS_IDX_STATUS     3'd5
`define RCS_ADDR_OUTCFG    12'h004
`define RCS_ADDR_MODE      12'h008
`define RCS_ADDR_DEVCFG    12'h00c
`define RCS_ADDR_STATUS    12'h014
`define RCS_MODE_AUTO_BIT  2
`define RCS_ALARM_LSB      4
`define RCS_SLEW_BIT       5
`define RCS_INTEN_BIT      4
`define RCS_ST_INT_BIT     7
`define RCS_ST_FAIL_LSB    3
`define RCS_ST_UNLOCK_BIT  2
`define RCS_RST_OUTCFG     8'h00
`define RCS_RST_MODE       3'h0
`define RCS_RST_BANKEN     4'h0
`define RCS_PRE_OUTCFG     8'h0a
`define RCS_PRE_MODE       3'h4
`define RCS_PRE_BANKEN     4'hf
`endif

// [src/rcs_pkg.sv]
// Types shared by the clock switch supervisor
package rcs_pkg;
	typedef enum logic [1:0] {
		RCS_SW_IDLE = 2'b00,
		RCS_SW_WAIT = 2'b01,
		RCS_SW_SLEW = 2'b10
	} rcs_sw_t;

	// Live conditions from the analog side and the failure detectors
	typedef struct packed {
		logic [3:0] ref_fail;
		logic [3:0] ref_qualified;
		logic [3:0] ref_rise;
		logic       pll_locked;
		logic       phase_aligned;
		logic       feedback_present;
	} rcs_pll_in_t;

	typedef struct packed {
		logic [1:0] sync;
		logic       clr_prev;
		logic       started;
		logic       configured;
		logic       boot_store;
		logic       catastrophic;
		logic [2:0] switch_mode_select;
		logic [7:0] out_cfg;
		logic [3:0] bank_en;
		logic       int_en;
		logic       slew_lagging;
		logic [3:0] fail_flag;
		logic       int_flag;
		logic [1:0] ref_sel;
		logic [1:0] ref_target;
		rcs_sw_t    sw;
		logic       busy;
		logic       slew_step;
		logic       unlocked;
		logic       irq_oe_n;
		logic       pready;
		logic       pslverr;
		logic [31:0] prdata;
	} rcs_state_t;
endpackage

// [src/rcs_supervisor.sv]
// Control and status logic of a four-input redundant reference clock switch
`timescale 1ns/10ps
`include "rcs_defs.svh"
module rcs_supervisor
	import rcs_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire rcs_pll_in_t pll_in,
	input  wire logic        alarm_clear_n,
	input  wire logic        preset_strap,
	input  wire logic        boot_source_strap,
	input  wire logic        external_feedback_select,
	output logic             irq_o,
	output logic             irq_oe_n,
	output logic             lock_n,
	output logic             busy,
	output logic [1:0]       selected_input,
	output logic [3:0]       fail_status,
	output logic [3:0]       bank_enable,
	output logic [7:0]       bank_divider,
	output logic             slew_lagging,
	output logic             slew_step,
	output logic             boot_from_store
);
	rcs_state_t s_q;
	rcs_state_t s_d;
	logic [3:0] ref_ok;
	logic       acc;
	logic       rd_status;
	logic       wr_mode;
	logic       wr_devcfg;
	logic       wr_outcfg;
	logic       clr_pulse;
	logic [1:0] next_auto;
	logic       have_next;
	logic [7:0] status_byte;

	// An input may carry the reference only if qualified and not failing now
	assign ref_ok = pll_in.ref_qualified & ~pll_in.ref_fail;

	// Bus access takes effect on the edge where pready is seen high
	assign acc       = psel & penable & s_q.pready;
	assign rd_status = acc & ~pwrite & (paddr == `RCS_ADDR_STATUS);
	assign wr_mode   = acc & pwrite & (paddr == `RCS_ADDR_MODE);
	assign wr_devcfg = acc & pwrite & (paddr == `RCS_ADDR_DEVCFG);
	assign wr_outcfg = acc & pwrite & (paddr == `RCS_ADDR_OUTCFG);

	// Only the second synchroniser stage and its delayed copy see the edge
	assign clr_pulse = s_q.clr_prev & ~s_q.sync[1];

	assign status_byte = {s_q.int_flag, s_q.fail_flag, s_q.unlocked, s_q.ref_sel};

	// Round-robin search from the current reference for the next usable input
	always_comb begin
		next_auto = s_q.ref_sel;
		have_next = 1'b0;
		for (int k = 3; k >= 1; k--) begin
			if (ref_ok[2'(s_q.ref_sel + 2'(k))]) begin
				next_auto = 2'(s_q.ref_sel + 2'(k));
				have_next = 1'b1;
			end
		end
	end

	// Whole next state of the block
	always_comb begin
		s_d = s_q;
		s_d.sync      = {s_q.sync[0], alarm_clear_n};
		s_d.clr_prev  = s_q.sync[1];
		s_d.slew_step = 1'b0;
		s_d.started   = 1'b1;
		// Straps are sampled on the first edge after reset release, never by the reset
		if (!s_q.started) begin
			s_d.boot_store = boot_source_strap;
			if (preset_strap) begin
				s_d.switch_mode_select = `RCS_PRE_MODE;
				s_d.out_cfg    = `RCS_PRE_OUTCFG;
				s_d.bank_en    = `RCS_PRE_BANKEN;
				s_d.int_en     = 1'b1;
				s_d.configured = 1'b1;
			end else begin
				s_d.bank_en    = `RCS_RST_BANKEN;
				s_d.configured = 1'b0;
			end
		end
		// Sticky flags; a failure in the clearing cycle wins over the clear
		if (clr_pulse) begin
			s_d.fail_flag = 4'h0;
		end else if (wr_mode) begin
			s_d.fail_flag = s_q.fail_flag & pwdata[`RCS_ALARM_LSB +: 4];
		end
		s_d.fail_flag = s_d.fail_flag | pll_in.ref_fail;
		// Configuration writes; nothing but the master reset restores defaults
		if (wr_mode) begin
			s_d.switch_mode_select = pwdata[2:0];
			s_d.configured = 1'b1;
		end
		if (wr_devcfg) begin
			s_d.bank_en      = pwdata[3:0];
			s_d.int_en       = pwdata[`RCS_INTEN_BIT];
			s_d.slew_lagging = pwdata[`RCS_SLEW_BIT];
			s_d.configured   = 1'b1;
		end
		if (wr_outcfg) begin
			s_d.out_cfg    = pwdata[7:0];
			s_d.configured = 1'b1;
		end
		// Reference selection requests
		if (s_q.sw == RCS_SW_IDLE && !s_q.catastrophic) begin
			if (clr_pulse || wr_mode) begin
				// Alarm pin and mode writes both aim at the mode's primary input
				if (ref_ok[s_d.switch_mode_select[1:0]] &&
				    s_d.switch_mode_select[1:0] != s_q.ref_sel) begin
					s_d.ref_target = s_d.switch_mode_select[1:0];
					s_d.sw = RCS_SW_WAIT;
				end
			end else if (s_q.switch_mode_select[`RCS_MODE_AUTO_BIT] && s_q.configured &&
			             !ref_ok[s_q.ref_sel] && have_next) begin
				s_d.ref_target = next_auto;
				s_d.sw = RCS_SW_WAIT;
			end
		end
		case (s_q.sw)
			RCS_SW_IDLE: begin
				s_d.busy = 1'b0;
			end
			RCS_SW_WAIT: begin
				s_d.busy = 1'b1;
				if (pll_in.ref_rise[s_q.ref_target]) begin
					s_d.ref_sel = s_q.ref_target;
					s_d.sw = RCS_SW_SLEW;
				end
			end
			RCS_SW_SLEW: begin
				// One small feedback nudge per edge of the new reference
				s_d.slew_step = pll_in.ref_rise[s_q.ref_sel] & ~pll_in.phase_aligned;
				if (pll_in.phase_aligned) begin
					s_d.busy = 1'b0;
					s_d.sw = RCS_SW_IDLE;
				end
			end
			default: begin
				s_d.sw = RCS_SW_IDLE;
			end
		endcase
		// Catastrophic failure holds until the master reset
		if (s_q.configured && (ref_ok == 4'h0 ||
		    (external_feedback_select && !pll_in.feedback_present))) begin
			s_d.catastrophic = 1'b1;
		end
		if (s_d.catastrophic) begin
			s_d.busy = 1'b0;
			s_d.sw = RCS_SW_IDLE;
		end
		s_d.unlocked = ~(s_q.configured & pll_in.pll_locked & ~s_q.catastrophic);
		// Interrupt flag: a new cause in the reading cycle keeps it set
		if (rd_status) begin
			s_d.int_flag = 1'b0;
		end
		if (s_q.int_en && (s_q.fail_flag != 4'h0 || s_q.unlocked)) begin
			s_d.int_flag = 1'b1;
		end
		// Line is pulled only while enabled, so masking also drops a pending request
		s_d.irq_oe_n = ~(s_d.int_flag & s_d.int_en);
		// One wait state: pready rises in the second access cycle
		s_d.pready  = psel & penable & ~s_q.pready;
		s_d.pslverr = 1'b0;
		s_d.prdata  = 32'h0;
		if (psel & penable & ~s_q.pready) begin
			case (paddr)
				`RCS_ADDR_OUTCFG: s_d.prdata = {24'h0, s_q.out_cfg};
				`RCS_ADDR_MODE:   s_d.prdata = {24'h0, 4'hf, 1'b0, s_q.switch_mode_select};
				`RCS_ADDR_DEVCFG: s_d.prdata = {26'h0, s_q.slew_lagging, s_q.int_en, s_q.bank_en};
				`RCS_ADDR_STATUS: s_d.prdata = {24'h0, status_byte};
				default:          s_d.pslverr = 1'b1;
			endcase
		end
	end

	// Asynchronous master reset loads constants only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.sync <= 2'b11;
			s_q.clr_prev <= 1'b1;
			s_q.switch_mode_select <= `RCS_RST_MODE;
			s_q.out_cfg <= `RCS_RST_OUTCFG;
			s_q.unlocked <= 1'b1;
			s_q.irq_oe_n <= 1'b1;
			s_q.sw <= RCS_SW_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign pready          = s_q.pready;
	assign prdata          = s_q.prdata;
	assign pslverr         = s_q.pslverr;
	assign irq_o           = 1'b0;
	assign irq_oe_n        = s_q.irq_oe_n;
	assign lock_n          = s_q.unlocked;
	assign busy            = s_q.busy;
	assign selected_input  = s_q.ref_sel;
	assign fail_status     = s_q.fail_flag;
	assign bank_enable     = s_q.bank_en;
	assign bank_divider    = s_q.out_cfg;
	assign slew_lagging    = s_q.slew_lagging;
	assign slew_step       = s_q.slew_step;
	assign boot_from_store = s_q.boot_store;

	property p_fail_sticky;
		@(posedge pclk) disable iff (!presetn)
		pll_in.ref_fail[0] |=> s_q.fail_flag[0];
	endproperty
	a_fail_sticky: assert property (p_fail_sticky) else $error("Flag 0 not set");

	property p_pin_clear;
		@(posedge pclk) disable iff (!presetn)
		(clr_pulse && pll_in.ref_fail == 4'h0) |=> s_q.fail_flag == 4'h0;
	endproperty
	a_pin_clear: assert property (p_pin_clear) else $error("Pin clear missed");

	property p_reg_clear_keeps_ref;
		@(posedge pclk) disable iff (!presetn)
		(wr_mode && s_q.sw == RCS_SW_IDLE && pwdata[2:0] == {1'b1, s_q.ref_sel})
		|=> $stable(s_q.ref_sel) && s_q.sw == RCS_SW_IDLE;
	endproperty
	a_reg_clear_keeps_ref: assert property (p_reg_clear_keeps_ref) else $error("Ref moved");

	property p_manual_invalid;
		@(posedge pclk) disable iff (!presetn)
		(wr_mode && s_q.sw == RCS_SW_IDLE && !ref_ok[pwdata[1:0]]) |=> s_q.sw == RCS_SW_IDLE;
	endproperty
	a_manual_invalid: assert property (p_manual_invalid) else $error("Bad switch");

	property p_irq_gated;
		@(posedge pclk) disable iff (!presetn)
		(!s_q.int_en && !wr_devcfg && s_q.started) |=> irq_oe_n;
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("Ungated irq");

	property p_irq_raise;
		@(posedge pclk) disable iff (!presetn)
		(s_q.int_en && s_q.fail_flag != 4'h0 && !wr_devcfg) |=> !irq_oe_n;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("Irq not raised");

	property p_read_clears;
		@(posedge pclk) disable iff (!presetn)
		(rd_status && !s_q.int_en) |=> !s_q.int_flag;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("Read kept flag");

	property p_catastrophic;
		@(posedge pclk) disable iff (!presetn)
		s_q.catastrophic |=> lock_n && !busy;
	endproperty
	a_catastrophic: assert property (p_catastrophic) else $error("Bad catastrophe");

	property p_switch_edge;
		@(posedge pclk) disable iff (!presetn)
		(s_q.sw == RCS_SW_WAIT && pll_in.ref_rise[s_q.ref_target] && !s_d.catastrophic)
		|=> selected_input == $past(s_q.ref_target, 1) && busy;
	endproperty
	a_switch_edge: assert property (p_switch_edge) else $error("Switch late");

	property p_fail_hold;
		@(posedge pclk) disable iff (!presetn)
		(!clr_pulse && !wr_mode)
		|=> (s_q.fail_flag & $past(s_q.fail_flag, 1)) == $past(s_q.fail_flag, 1);
	endproperty
	a_fail_hold: assert property (p_fail_hold) else $error("Flag lost");

	property p_busy_rise;
		@(posedge pclk) disable iff (!presetn)
		(s_q.sw == RCS_SW_WAIT && !s_d.catastrophic) |=> busy;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("Busy missing");

	property p_unlock_start;
		@(posedge pclk) disable iff (!presetn)
		!s_q.configured |=> lock_n;
	endproperty
	a_unlock_start: assert property (p_unlock_start) else $error("Lock too early");

	property p_preset_start;
		@(posedge pclk) disable iff (!presetn)
		(!s_q.started && preset_strap)
		|=> (bank_enable == `RCS_PRE_BANKEN) && (bank_divider == `RCS_PRE_OUTCFG);
	endproperty
	a_preset_start: assert property (p_preset_start) else $error("Bad preset");

	property p_idle_start;
		@(posedge pclk) disable iff (!presetn)
		(!s_q.started && !preset_strap) |=> (bank_enable == `RCS_RST_BANKEN) && lock_n;
	endproperty
	a_idle_start: assert property (p_idle_start) else $error("Bad idle start");

	property p_slew_pulse;
		@(posedge pclk) disable iff (!presetn)
		(s_q.sw == RCS_SW_SLEW && pll_in.ref_rise[s_q.ref_sel] && !pll_in.phase_aligned)
		|=> slew_step;
	endproperty
	a_slew_pulse: assert property (p_slew_pulse) else $error("Nudge missing");

	property p_alarm_pulse;
		@(posedge pclk) disable iff (!presetn)
		clr_pulse |=> !clr_pulse;
	endproperty
	a_alarm_pulse: assert property (p_alarm_pulse) else $error("Long clear");
endmodule // rcs_supervisor

// [test/rcs_host_line.sv]
// Host side of the open-drain interrupt line, with its pull-up
`timescale 1ns/10ps
module rcs_host_line (
	input  wire logic irq_o,
	input  wire logic irq_oe_n,
	output logic      irq_line_n
);
	// Released line floats to the pull-up level, never the last value
	assign irq_line_n = irq_oe_n ? 1'b1 : irq_o;
endmodule // rcs_host_line

// [test/rcs_supervisor_tb.sv]
// Self-checking bench of the clock switch supervisor
`timescale 1ns/10ps
`include "rcs_defs.svh"
module rcs_supervisor_tb;
	import rcs_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	rcs_pll_in_t pin;
	logic        alarm_clear_n, preset_strap, irq_o, irq_oe_n, irq_line_n;
	logic        lock_n, busy, slew_lagging, err, slew_step, boot_from_store, boot_strap, ext_fb;
	logic [1:0]  selected_input;
	logic [3:0]  fail_status, bank_enable;
	logic [7:0]  bank_divider;
	int          n_mismatch, n_checks;

	rcs_supervisor DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .pll_in(pin), .alarm_clear_n(alarm_clear_n),
		.preset_strap(preset_strap), .boot_source_strap(boot_strap),
		.external_feedback_select(ext_fb), .irq_o(irq_o), .irq_oe_n(irq_oe_n),
		.lock_n(lock_n), .busy(busy), .selected_input(selected_input),
		.fail_status(fail_status), .bank_enable(bank_enable), .bank_divider(bank_divider),
		.slew_lagging(slew_lagging), .slew_step(slew_step), .boot_from_store(boot_from_store));
	rcs_host_line host (.irq_o(irq_o), .irq_oe_n(irq_oe_n), .irq_line_n(irq_line_n));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		if (w && busy !== 1'b0) chk("idle_write", 0, busy);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 50) chk("pready", 1, 0);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// First rising edge switches, second one nudges the feedback, then realignment ends it
	task automatic sw_done(input logic [1:0] s);
		repeat (2) begin
			pin.ref_rise <= 4'hf;
			wt(1);
			pin.ref_rise <= 4'h0;
			wt(1);
		end
		chk("selected", s, selected_input);
		chk("slew_step", 1, slew_step);
		pin.phase_aligned <= 1'b1;
		wt(3);
		chk("busy_end", 0, busy);
		pin.phase_aligned <= 1'b0;
	endtask

	task automatic t_preset;
		chk("banks", 4'hf, bank_enable);
		chk("divider", 8'h0a, bank_divider);
		chk("lock", 0, lock_n);
		apb(1'b1, `RCS_ADDR_DEVCFG, 32'h3f);
		wt(2);
		chk("slew", 1, slew_lagging);
		apb(1'b0, 12'h040, 32'h0);
		chk("slverr", 1, err);
	endtask

	task automatic t_auto;
		pin.ref_fail[0] <= 1'b1;
		wt(3);
		chk("busy", 1, busy);
		pin.ref_fail[0] <= 1'b0;
		sw_done(2'd1);
		chk("flags", 4'h1, fail_status);
		chk("irq", 0, irq_line_n);
		apb(1'b0, `RCS_ADDR_STATUS, 32'h0);
		chk("status", 8'h89, rd[7:0]);
		alarm_clear_n <= 1'b0;
		wt(5);
		chk("flags_pin", 4'h0, fail_status);
		sw_done(2'd0);
		alarm_clear_n <= 1'b1;
		apb(1'b0, `RCS_ADDR_STATUS, 32'h0);
		chk("status_int", 8'h80, rd[7:0]);
		apb(1'b0, `RCS_ADDR_STATUS, 32'h0);
		chk("status_clr", 8'h00, rd[7:0]);
		chk("irq_off", 1, irq_line_n);
	endtask

	task automatic t_manual;
		apb(1'b1, `RCS_ADDR_MODE, 32'hf2);
		wt(2);
		chk("busy_man", 1, busy);
		sw_done(2'd2);
		apb(1'b0, `RCS_ADDR_STATUS, 32'h0);
		chk("status_sel", 8'h02, rd[7:0]);
		pin.ref_qualified[3] <= 1'b0;
		apb(1'b1, `RCS_ADDR_MODE, 32'hf3);
		wt(3);
		chk("no_switch", 2'd2, selected_input);
		chk("no_busy", 0, busy);
		pin.ref_qualified[3] <= 1'b1;
	endtask

	task automatic t_clear_one;
		pin.ref_fail[1] <= 1'b1;
		wt(2);
		pin.ref_fail[1] <= 1'b0;
		wt(2);
		chk("flag1", 4'h2, fail_status);
		apb(1'b1, `RCS_ADDR_MODE, 32'hd6);
		wt(2);
		chk("flag1_clr", 4'h0, fail_status);
		chk("keep_sel", 2'd2, selected_input);
		apb(1'b1, `RCS_ADDR_DEVCFG, 32'h2f);
		apb(1'b0, `RCS_ADDR_STATUS, 32'h0);
		pin.ref_fail[2] <= 1'b1;
		wt(2);
		pin.ref_fail[2] <= 1'b0;
		wt(3);
		chk("flag2", 4'h4, fail_status);
		chk("irq_masked", 1, irq_line_n);
	endtask

	// Catastrophe, then master reset with the strap low
	task automatic t_cat;
		pin.ref_qualified <= 4'h0;
		wt(5);
		chk("cat_lock", 1, lock_n);
		chk("cat_busy", 0, busy);
		pin.ref_qualified <= 4'hf;
		preset_strap <= 1'b0;
		presetn <= 1'b0;
		boot_strap <= 1'b1;
		wt(20);
		presetn <= 1'b1;
		wt(3);
		chk("idle_banks", 4'h0, bank_enable);
		chk("idle_div", 8'h00, bank_divider);
		chk("idle_lock", 1, lock_n);
		chk("idle_flags", 4'h0, fail_status);
		chk("boot", 1, boot_from_store);
		apb(1'b1, `RCS_ADDR_OUTCFG, 32'h5a);
		wt(2);
		chk("cfg_div", 8'h5a, bank_divider);
		chk("cfg_lock", 0, lock_n);
		// External feedback selected but absent is the second catastrophic cause
		ext_fb <= 1'b1;
		pin.feedback_present <= 1'b0;
		wt(3);
		chk("fb_lock", 1, lock_n);
		chk("fb_busy", 0, busy);
	endtask

	task automatic final_report;
		if (n_mismatch == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata, pin, boot_strap, ext_fb} = '0;
		pin.ref_qualified = 4'hf;
		pin.pll_locked = 1'b1;
		pin.feedback_present = 1'b1;
		alarm_clear_n = 1'b1;
		preset_strap = 1'b1;
		presetn = 1'b0;
		wt(20);
		presetn <= 1'b1;
		wt(3);
		t_preset();
		t_auto();
		t_manual();
		t_clear_one();
		t_cat();
		final_report();
	end

	// Bounds a hang well beyond the roughly 150 cycles the tests need
	initial begin
		wt(20000);
		n_mismatch++;
		final_report();
	end
endmodule // rcs_supervisor_tb
